/* src/flash_rc_pacer.sv */
// package with the flash map and timing defaults, and the pacer that stands in
// for the internal rc oscillator while program or erase pulses run.
// assumes one system clock; the oscillator is modelled as a tick enable.
`timescale 1ns/100ps

//==========================================================================
// package
//==========================================================================
package flash_ctl_pkg;
   localparam int WORD_W = 32;
   localparam int HADDR_W = 32;
   localparam int IDX_W = 14;                        // word index in one region
   localparam int ARR_ADDR_W = 15;                   // region bit plus word index
   localparam int PAGE_W = 6;                        // 64 user pages
   localparam int RAM_AW = 12;
   localparam int CNT_W = 16;
   localparam logic [31:0] USER_BASE = 32'h00000000;
   localparam logic [31:0] BOOT_BASE = 32'h1fff0000;
   localparam int USER_TOP = 15;                     // user byte address bits 15:0
   localparam int BOOT_TOP = 11;                     // four 1 KiB boot pages
   localparam int WORD_LSB = 2;
   localparam int PAGE_LSB = 10;                     // byte bit of the page index
   localparam int PAGE_IDX_LSB = PAGE_LSB - WORD_LSB; // same bit in word index
   localparam logic [31:0] ERASED_WORD = 32'hffffffff;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic HRESP_ERROR = 1'h1;
   localparam int DEF_RC_DIV = 4;                    // system clocks per rc tick
   localparam int DEF_OSC_SETTLE = 8;                // rc ticks before first pulse
   localparam int DEF_PROG_TICKS = 8;
   localparam int DEF_ERASE_TICKS = 32;

   // map a bus address onto the array: {hit, region, word index}
   function automatic logic [ARR_ADDR_W:0] flash_map(input logic [HADDR_W-1:0] a);
      logic [ARR_ADDR_W:0] r;
      r = '0;
      if (a[HADDR_W-1:USER_TOP+1] == USER_BASE[HADDR_W-1:USER_TOP+1]) begin
         r = {1'h1, 1'h0, a[USER_TOP:WORD_LSB]};
      end else if (a[HADDR_W-1:BOOT_TOP+1] == BOOT_BASE[HADDR_W-1:BOOT_TOP+1]) begin
         r = {1'h1, 1'h1, {(IDX_W-BOOT_TOP+WORD_LSB-1){1'h0}}, a[BOOT_TOP:WORD_LSB]};
      end
      return r;
   endfunction : flash_map
endpackage : flash_ctl_pkg

//==========================================================================
// rc oscillator pacer
//==========================================================================
module flash_rc_pacer import flash_ctl_pkg::*; #(
   parameter int RC_DIV = DEF_RC_DIV,
   parameter int OSC_SETTLE = DEF_OSC_SETTLE
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // request from the sequencer
   input wire logic osc_on,
   // oscillator state
   output logic rc_osc_en,
   output logic osc_ready,
   output logic rc_tick
);
   logic [CNT_W-1:0] div_r, div_nxt;
   logic [CNT_W-1:0] settle_r, settle_nxt;
   logic en_r, en_nxt;

   // refuse pacing values that the counters cannot hold
   if (RC_DIV < 1 || RC_DIV >= 2**CNT_W) begin : g_bad_div
      $error("RC_DIV out of range");
   end
   if (OSC_SETTLE < 1 || OSC_SETTLE >= 2**CNT_W) begin : g_bad_settle
      $error("OSC_SETTLE out of range");
   end

   // divider only runs while the oscillator is on, so no tick leaks out idle
   always_comb begin
      en_nxt = osc_on;
      div_nxt = div_r;
      settle_nxt = settle_r;
      rc_tick = 1'h0;
      if (!en_r) begin
         div_nxt = '0;
         settle_nxt = '0;
      end else if (div_r == CNT_W'(RC_DIV - 1)) begin
         div_nxt = '0;
         rc_tick = 1'h1;
         if (settle_r != CNT_W'(OSC_SETTLE)) settle_nxt = settle_r + 1'h1;
      end else begin
         div_nxt = div_r + 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         en_r <= 1'h0;
         div_r <= '0;
         settle_r <= '0;
      end else begin
         en_r <= en_nxt;
         div_r <= div_nxt;
         settle_r <= settle_nxt;
      end
   end

   assign rc_osc_en = en_r;
   assign osc_ready = en_r && (settle_r == CNT_W'(OSC_SETTLE));
endmodule : flash_rc_pacer

/* src/flash_op_controller.sv */
// embedded flash controller: ahb read path and word program / page erase sequencer.
// assumes an array with one-cycle read latency and a ram with one-cycle latency.
`timescale 1ns/100ps

module flash_op_controller import flash_ctl_pkg::*; #(
   parameter int RC_DIV = DEF_RC_DIV,
   parameter int OSC_SETTLE = DEF_OSC_SETTLE,
   parameter int PROG_TICKS = DEF_PROG_TICKS,
   parameter int ERASE_TICKS = DEF_ERASE_TICKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // ahb slave
   input wire logic hsel,
   input wire logic [HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [WORD_W-1:0] hrdata,
   // operation request
   input wire logic op_req,
   input wire logic op_erase,
   input wire logic [HADDR_W-1:0] op_addr,
   input wire logic [RAM_AW-1:0] op_ram_addr,
   output logic op_ack,
   output logic op_done,
   output logic busy,
   output logic program_error_flag,
   input wire logic err_clr,
   output logic cpu_stall,
   // ram read port
   output logic ram_rd,
   output logic [RAM_AW-1:0] ram_addr,
   input wire logic [WORD_W-1:0] ram_rdata,
   // array port
   output logic arr_rd,
   output logic [ARR_ADDR_W-1:0] arr_addr,
   input wire logic [WORD_W-1:0] arr_rdata,
   output logic arr_prog,
   output logic [WORD_W-1:0] arr_wdata,
   output logic arr_erase,
   output logic arr_page_boot,
   output logic [PAGE_W-1:0] arr_page,
   // oscillator
   output logic internal_rc_oscillator
);
   typedef enum logic [2:0] {A_IDLE, A_WAIT, A_CAPT, A_DONE, A_ERR1, A_ERR2} ahb_st_t;
   typedef enum logic [2:0] {S_IDLE, S_RAM, S_RAMD, S_CHK, S_CHKD, S_OSC, S_PULSE,
                             S_FIN} seq_st_t;

   // pulse lengths must fit the tick counter
   if (PROG_TICKS < 1 || PROG_TICKS >= 2**CNT_W) begin : g_bad_prog
      $error("PROG_TICKS out of range");
   end
   if (ERASE_TICKS < 1 || ERASE_TICKS >= 2**CNT_W) begin : g_bad_erase
      $error("ERASE_TICKS out of range");
   end

   //=======================================================================
   // ahb read path
   //=======================================================================
   ahb_st_t ahb_r, ahb_nxt;
   logic [ARR_ADDR_W-1:0] raddr_r, raddr_nxt;
   logic [WORD_W-1:0] hrdata_r, hrdata_nxt;
   logic [ARR_ADDR_W:0] hmap;
   logic accept;
   logic rd_req;
   logic busy_w;

   assign hmap = flash_map(haddr);
   assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);

   // hsize is ignored: the array always hands back a whole word
   always_comb begin
      ahb_nxt = ahb_r;
      raddr_nxt = raddr_r;
      hrdata_nxt = hrdata_r;
      rd_req = 1'h0;
      case (ahb_r)
         A_IDLE, A_DONE, A_ERR2: begin
            ahb_nxt = A_IDLE;
            if (accept) begin
               raddr_nxt = hmap[ARR_ADDR_W-1:0];
               // bus writes never reach the array: error answer
               if (hwrite || !hmap[ARR_ADDR_W]) ahb_nxt = A_ERR1;
               else ahb_nxt = A_WAIT;
            end
         end
         A_WAIT: begin
            // parked here while an operation owns the array
            if (!busy_w) begin
               rd_req = 1'h1;
               ahb_nxt = A_CAPT;
            end
         end
         A_CAPT: begin
            hrdata_nxt = arr_rdata;
            ahb_nxt = A_DONE;
         end
         A_ERR1: ahb_nxt = A_ERR2;
         default: ahb_nxt = A_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ahb_r <= A_IDLE;
         raddr_r <= '0;
         hrdata_r <= '0;
      end else begin
         ahb_r <= ahb_nxt;
         raddr_r <= raddr_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   assign hreadyout = (ahb_r == A_IDLE) || (ahb_r == A_DONE) || (ahb_r == A_ERR2);
   assign hresp = (ahb_r == A_ERR1 || ahb_r == A_ERR2) ? HRESP_ERROR : HRESP_OKAY;
   assign hrdata = hrdata_r;

   //=======================================================================
   // program / erase sequencer
   //=======================================================================
   seq_st_t seq_r, seq_nxt;
   logic erase_r, erase_nxt;
   logic [ARR_ADDR_W-1:0] oaddr_r, oaddr_nxt;
   logic [RAM_AW-1:0] raddr_ram_r, raddr_ram_nxt;
   logic [WORD_W-1:0] wdata_r, wdata_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic err_r, err_nxt;
   logic err_set;
   logic [ARR_ADDR_W:0] omap;
   logic osc_on;
   logic osc_ready;
   logic rc_tick;
   logic [CNT_W-1:0] pulse_last;

   assign omap = flash_map(op_addr);
   assign pulse_last = erase_r ? CNT_W'(ERASE_TICKS - 1) : CNT_W'(PROG_TICKS - 1);

   // a start is refused only in the one cycle a bus read takes the array
   always_comb begin
      seq_nxt = seq_r;
      erase_nxt = erase_r;
      oaddr_nxt = oaddr_r;
      raddr_ram_nxt = raddr_ram_r;
      wdata_nxt = wdata_r;
      cnt_nxt = cnt_r;
      err_set = 1'h0;
      op_ack = 1'h0;
      case (seq_r)
         S_IDLE: begin
            if (op_req && !rd_req) begin
               op_ack = 1'h1;
               erase_nxt = op_erase;
               oaddr_nxt = omap[ARR_ADDR_W-1:0];
               raddr_ram_nxt = op_ram_addr;
               if (!omap[ARR_ADDR_W]) begin
                  err_set = 1'h1;                         // illegal address
                  seq_nxt = S_FIN;
               end else if (op_erase) begin
                  seq_nxt = S_OSC;
               end else begin
                  seq_nxt = S_RAM;
               end
            end
         end
         S_RAM: seq_nxt = S_RAMD;
         S_RAMD: begin
            wdata_nxt = ram_rdata;
            seq_nxt = S_CHK;
         end
         S_CHK: seq_nxt = S_CHKD;
         S_CHKD: begin
            if (arr_rdata != ERASED_WORD) begin
               err_set = 1'h1;
               seq_nxt = S_FIN;
            end else begin
               seq_nxt = S_OSC;
            end
         end
         S_OSC: begin
            cnt_nxt = '0;
            if (osc_ready) seq_nxt = S_PULSE;
         end
         S_PULSE: begin
            // pulse length counted in rc ticks, not system clocks
            if (rc_tick) begin
               cnt_nxt = cnt_r + 1'h1;
               if (cnt_r == pulse_last) seq_nxt = S_FIN;
            end
         end
         S_FIN: seq_nxt = S_IDLE;
         default: seq_nxt = S_IDLE;
      endcase
      // a new error wins over a clear in the same cycle
      if (err_set) err_nxt = 1'h1;
      else if (err_clr) err_nxt = 1'h0;
      else err_nxt = err_r;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         seq_r <= S_IDLE;
         erase_r <= 1'h0;
         oaddr_r <= '0;
         raddr_ram_r <= '0;
         wdata_r <= '0;
         cnt_r <= '0;
         err_r <= 1'h0;
      end else begin
         seq_r <= seq_nxt;
         erase_r <= erase_nxt;
         oaddr_r <= oaddr_nxt;
         raddr_ram_r <= raddr_ram_nxt;
         wdata_r <= wdata_nxt;
         cnt_r <= cnt_nxt;
         err_r <= err_nxt;
      end
   end

   // busy from start to finish; only the cpu is stalled, the rest keeps clk
   assign busy_w = (seq_r != S_IDLE);
   assign busy = busy_w;
   assign cpu_stall = busy_w;
   assign op_done = (seq_r == S_FIN);
   assign program_error_flag = err_r;
   assign osc_on = (seq_r == S_OSC) || (seq_r == S_PULSE);

   //=======================================================================
   // array and ram ports
   //=======================================================================
   assign ram_rd = (seq_r == S_RAM);
   assign ram_addr = raddr_ram_r;
   assign arr_rd = rd_req || (seq_r == S_CHK);
   assign arr_addr = busy_w ? oaddr_r : raddr_r;
   assign arr_wdata = wdata_r;
   assign arr_prog = (seq_r == S_PULSE) && !erase_r;
   assign arr_erase = (seq_r == S_PULSE) && erase_r;
   assign arr_page_boot = oaddr_r[ARR_ADDR_W-1];
   assign arr_page = oaddr_r[IDX_W-1:PAGE_IDX_LSB];

   flash_rc_pacer #(
      .RC_DIV(RC_DIV),
      .OSC_SETTLE(OSC_SETTLE)
   ) u_pacer (
      .clk(clk),
      .resetn(resetn),
      .osc_on(osc_on),
      .rc_osc_en(internal_rc_oscillator),
      .osc_ready(osc_ready),
      .rc_tick(rc_tick)
   );
endmodule : flash_op_controller

/* testbench/flash_op_checker_sva.sv */
// port assertions for the flash controller: bus wait states, stall, rc use.
// assumes a single ahb slave whose hready input is its own hreadyout.
`timescale 1ns/100ps

//==========================================================================
// checker
//==========================================================================
module flash_op_checker import flash_ctl_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // ahb slave
   input wire logic hsel,
   input wire logic [HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // operation port
   input wire logic op_ack,
   input wire logic op_done,
   input wire logic busy,
   input wire logic program_error_flag,
   input wire logic cpu_stall,
   // array and oscillator
   input wire logic arr_rd,
   input wire logic arr_prog,
   input wire logic arr_erase,
   input wire logic internal_rc_oscillator
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // address phase decode; both flash regions are the only mapped space
   logic take;
   logic mapped;
   assign take = hsel && hready && htrans[1];
   assign mapped = (haddr[31:16] == 16'h0000) || (haddr[31:12] == 20'h1fff0);

   stall_is_busy_a: assert property (cpu_stall == busy)
      else $error("stall differs from busy");
   busy_after_ack_a: assert property (op_ack |=> busy)
      else $error("busy not set after ack");
   busy_ends_a: assert property (op_done |=> !busy)
      else $error("busy still set after done");
   read_path_a: assert property (take && !hwrite && mapped && !busy && !op_ack |=>
      arr_rd && !hreadyout ##1 !hreadyout) else $error("read strobe or waits wrong");
   read_stall_a: assert property (take && !hwrite && mapped && busy |=>
      !hreadyout [*2]) else $error("read not stalled while busy");
   bus_error_a: assert property (take && (hwrite || !mapped) |=>
      hresp && !hreadyout ##1 hresp && hreadyout) else $error("error response wrong");
   osc_paces_op_a: assert property ((arr_prog || arr_erase) |->
      internal_rc_oscillator && busy) else $error("array strobe without oscillator");
   error_ends_op_a: assert property ($rose(program_error_flag) |-> ##[0:3] !busy)
      else $error("error did not end operation");
endmodule : flash_op_checker

bind flash_op_controller flash_op_checker u_chk (.clk(clk), .resetn(resetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .op_ack(op_ack), .op_done(op_done), .busy(busy),
   .program_error_flag(program_error_flag), .cpu_stall(cpu_stall), .arr_rd(arr_rd),
   .arr_prog(arr_prog), .arr_erase(arr_erase), .internal_rc_oscillator(internal_rc_oscillator));

/* testbench/flash_array_model.sv */
// stand-in for the flash array and the source ram, one-cycle read latency.
// assumes program and erase act on the rising edge of their level strobes.
`timescale 1ns/100ps

//==========================================================================
// array and ram model
//==========================================================================
module flash_array_model import flash_ctl_pkg::*; (
   // clock
   input wire logic clk,
   // ram read port
   input wire logic ram_rd,
   input wire logic [RAM_AW-1:0] ram_addr,
   output logic [WORD_W-1:0] ram_rdata = '0,
   // array port
   input wire logic arr_rd,
   input wire logic [ARR_ADDR_W-1:0] arr_addr,
   output logic [WORD_W-1:0] arr_rdata = '0,
   input wire logic arr_prog,
   input wire logic [WORD_W-1:0] arr_wdata,
   input wire logic arr_erase,
   input wire logic arr_page_boot,
   input wire logic [PAGE_W-1:0] arr_page
);
   logic [WORD_W-1:0] mem [int];                  // absent key reads as erased
   logic prog_q = 1'b0;
   logic erase_q = 1'b0;
   int tgt = 0;

   // reads return whole words; idle outputs scramble so stale data never passes
   always @(posedge clk) begin
      prog_q <= arr_prog;
      erase_q <= arr_erase;
      ram_rdata <= ram_rd ? {20'ha5a50, ram_addr} : ~ram_rdata;
      arr_rdata <= !arr_rd ? ~arr_rdata :
         (mem.exists(int'(arr_addr)) ? mem[int'(arr_addr)] : ERASED_WORD);
      if (arr_rd) begin
         tgt = int'(arr_addr);                       // check read names the target
      end
      if (arr_prog && !prog_q) begin
         mem[tgt] = (mem.exists(tgt) ? mem[tgt] : ERASED_WORD) & arr_wdata;
      end
      if (arr_erase && !erase_q) begin
         for (int i = 0; i < 256; i++) begin
            mem.delete(int'({arr_page_boot, arr_page, 8'h00}) + i);
         end
      end
   end
endmodule : flash_array_model

/* testbench/embedded_flash_controller_tb_top.sv */
// self-checking bench: ahb reads, word program, page erase, stalls, errors.
// assumes default pacing parameters; drives the bus, operation, err_clr and reset inputs at the falling edge.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module embedded_flash_controller_tb_top import flash_ctl_pkg::*;;
   typedef struct {logic [31:0] a; logic wr; logic [31:0] d; logic r;} row_t;
   logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, op_req, op_erase;
   logic op_ack, op_done, busy, program_error_flag, err_clr, cpu_stall, ram_rd, arr_rd;
   logic arr_prog, arr_erase, arr_page_boot, internal_rc_oscillator, r;
   logic osc_seen = 1'b0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hrdata, op_addr, ram_rdata, arr_rdata, arr_wdata, d;
   logic [RAM_AW-1:0] op_ram_addr, ram_addr;
   logic [ARR_ADDR_W-1:0] arr_addr;
   logic [PAGE_W-1:0] arr_page;
   int n_mismatch = 0;
   int total_checks = 0;
   int w;
   row_t rows [8];

   flash_op_controller dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .op_req(op_req),
      .op_erase(op_erase), .op_addr(op_addr), .op_ram_addr(op_ram_addr), .op_ack(op_ack),
      .op_done(op_done), .busy(busy), .program_error_flag(program_error_flag),
      .err_clr(err_clr), .cpu_stall(cpu_stall), .ram_rd(ram_rd), .ram_addr(ram_addr),
      .ram_rdata(ram_rdata), .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_rdata(arr_rdata),
      .arr_prog(arr_prog), .arr_wdata(arr_wdata), .arr_erase(arr_erase),
      .arr_page_boot(arr_page_boot), .arr_page(arr_page),
      .internal_rc_oscillator(internal_rc_oscillator));
   flash_array_model far_side (.clk(clk), .ram_rd(ram_rd), .ram_addr(ram_addr),
      .ram_rdata(ram_rdata), .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_rdata(arr_rdata),
      .arr_prog(arr_prog), .arr_wdata(arr_wdata), .arr_erase(arr_erase),
      .arr_page_boot(arr_page_boot), .arr_page(arr_page));
   assign hready = hreadyout;                      // lone slave on the bus

   // 10 MHz keeps the cpu clock under the program limit
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) if (internal_rc_oscillator === 1'b1) osc_seen = 1'b1;

   //=======================================================================
   // tasks
   //=======================================================================
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // one transfer; address phase held across the taking edge
   task ahb(input [31:0] a, input wr);
      @(negedge clk);
      hsel = 1'b1; haddr = a; htrans = HTRANS_NONSEQ; hwrite = wr;
      @(negedge clk);
      hsel = 1'b0; htrans = 2'h0;
      for (w = 0; w < 2000 && hreadyout !== 1'b1; w++) @(negedge clk);
      if (w == 2000) begin n_mismatch++; end_of_test(); end
      d = hrdata; r = hresp;
   endtask : ahb

   task rd(input [31:0] a, input [31:0] e);
      ahb(a, 1'b0);
      `CHK(d, e)
   endtask : rd

   task op(input e, input [31:0] a, input [11:0] ra);
      int i;
      @(negedge clk);
      op_req = 1'b1; op_erase = e; op_addr = a; op_ram_addr = ra;
      // ack is combinational and gone after its edge: look once it has settled
      #1;
      for (i = 0; i < 2000 && op_ack !== 1'b1; i++) begin
         @(negedge clk);
         #1;
      end
      if (i == 2000) begin n_mismatch++; end_of_test(); end
      // drop the request before the sequencer is idle again, so no repeat
      @(negedge clk);
      op_req = 1'b0;
      for (i = 0; i < 2000 && op_done !== 1'b1; i++) @(negedge clk);
      if (i == 2000) begin n_mismatch++; end_of_test(); end
      @(negedge clk);
   endtask : op

   //=======================================================================
   // main sequence
   //=======================================================================
   initial begin
      resetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      op_req = 1'b0; op_erase = 1'b0; op_addr = '0; op_ram_addr = '0; err_clr = 1'b0;
      rows = '{'{32'h0000_0404, 1'b0, 32'ha5a5_0005, 1'b0},
               '{32'h1fff_0c08, 1'b0, 32'ha5a5_0007, 1'b0},
               '{32'h0000_fffc, 1'b0, 32'ha5a5_0009, 1'b0},
               '{32'h0000_0400, 1'b0, ERASED_WORD, 1'b0},
               '{32'h1fff_0ffc, 1'b0, ERASED_WORD, 1'b0},
               '{32'h0001_0000, 1'b0, 32'h0, 1'b1},
               '{32'h1fff_1000, 1'b0, 32'h0, 1'b1},
               '{32'h0000_0000, 1'b1, 32'h0, 1'b1}};
      repeat (3) @(negedge clk);
      `CHK({hreadyout, hresp, busy, program_error_flag, internal_rc_oscillator}, 5'h10)
      resetn = 1'b1;
      op(1'b0, 32'h0000_0404, 12'h005);
      `CHK(osc_seen, 1'b1)
      `CHK({busy, program_error_flag}, 2'h0)
      op(1'b0, 32'h1fff_0c08, 12'h007);
      op(1'b0, 32'h0000_fffc, 12'h009);
      // ordinary reads and refused accesses from the table
      foreach (rows[k]) begin
         ahb(rows[k].a, rows[k].wr);
         `CHK(r, rows[k].r)
         if (rows[k].r === HRESP_OKAY) begin
            `CHK(d, rows[k].d)
            `CHK(w, 2)
         end
      end
      // program over a written word must be skipped and flagged
      op(1'b0, 32'h0000_0404, 12'h003);
      `CHK(program_error_flag, 1'b1)
      rd(32'h0000_0404, 32'ha5a5_0005);
      @(negedge clk) err_clr = 1'b1;
      @(negedge clk) err_clr = 1'b0;
      `CHK(program_error_flag, 1'b0)
      // first word of page 2 must survive the page 1 erase
      op(1'b0, 32'h0000_0800, 12'h00b);
      // erase page 1 by an address high in the page, with a read racing it
      fork
         op(1'b1, 32'h0000_07f0, 12'h000);
         begin
            repeat (8) @(negedge clk);
            ahb(32'h0000_0404, 1'b0);
         end
      join
      `CHK(d, ERASED_WORD)
      `CHK(w > 2, 1'b1)
      rd(32'h0000_07fc, ERASED_WORD);
      rd(32'h0000_0800, 32'ha5a5_000b);
      rd(32'h0000_fffc, 32'ha5a5_0009);
      rd(32'h1fff_0c08, 32'ha5a5_0007);
      op(1'b0, 32'h2000_0000, 12'h001);
      `CHK(program_error_flag, 1'b1)
      // reset in mid erase pulse: busy, flag and oscillator must all drop
      @(negedge clk);
      op_req = 1'b1; op_erase = 1'b1; op_addr = 32'h0000_fc00;
      @(negedge clk);
      op_req = 1'b0;
      `CHK(busy, 1'b1)
      repeat (50) @(negedge clk);
      `CHK({arr_erase, internal_rc_oscillator}, 2'h3)
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({hreadyout, hresp, busy, program_error_flag, internal_rc_oscillator}, 5'h10)
      resetn = 1'b1;
      rd(32'h1fff_0c08, 32'ha5a5_0007);
      end_of_test();
   end
endmodule : embedded_flash_controller_tb_top
